// ### msr_consts.vh
// constants for the mute status network responder
// Overview of operation
// R1: network side reads status only, never controls
// R2: answer reads of class 100 instance 1
// R3: attribute 1 operating mode codes 1 to 3
// R4: attribute 2 machine state codes 1 to 7
// R5: attributes 3,4 zone clear 1, interrupted 2
// R6: attribute 5 relays de-energized 1, energized 2
// R7: flags 6,7,43 enabled 1, disabled 2
// R8: attribute 8 curtain count one or two
// R9: attribute 9 sensor count code 1 to 3
// R10: attribute 10 two minutes 1, unlimited 2
// R11: attribute 11 fault 1, follow outputs 2
// R12: sensor attributes 12-16,31-33 clear 1, blocked 2
// R13: serial number is four bytes, moved attribute
// R14: poll returns one byte status image
// R15: status byte 0 bit layout fixed
// R16: bit strobe returns eight bytes, byte 0 same
// R17: strobe byte 1 holds mode and enable flags
// R18: strobe bytes 4,5,6 diag, curtains, sensors
// R19: change of byte 0 sends unsolicited message
// R20: change message carries poll byte layout
// R21: attribute 25 error code, zero means none
// R22: attribute 34 firmware version byte
// R23: run means both outputs on, stop both off
`ifndef MSR_CONSTS_VH
`define MSR_CONSTS_VH

`define MSR_KIND_EXPL 2'h0
`define MSR_KIND_POLL 2'h1
`define MSR_KIND_STRB 2'h2

`define MSR_CLS_STATUS 8'h64
`define MSR_CLS_ASM 8'h04
`define MSR_INST_ONE 8'h01
`define MSR_INST_TWO 8'h02
`define MSR_INST_THREE 8'h03
`define MSR_ASM_ATTR 8'h03

`define MSR_A_MODE 8'h01
`define MSR_A_STATE 8'h02
`define MSR_A_ZONE1 8'h03
`define MSR_A_ZONE2 8'h04
`define MSR_A_RELAY 8'h05
`define MSR_A_MONITOR 8'h06
`define MSR_A_BYPASS 8'h07
`define MSR_A_CURTAINS 8'h08
`define MSR_A_SENSORS 8'h09
`define MSR_A_TLIMIT 8'h0A
`define MSR_A_AUX 8'h0B
`define MSR_A_S1A 8'h0C
`define MSR_A_S1B 8'h0D
`define MSR_A_S1C 8'h0E
`define MSR_A_S1D 8'h0F
`define MSR_A_S2A 8'h10
`define MSR_A_ERROR 8'h19
`define MSR_A_S2B 8'h1F
`define MSR_A_S2C 8'h20
`define MSR_A_S2D 8'h21
`define MSR_A_FWVER 8'h22
`define MSR_A_MUTE 8'h2B
`define MSR_A_SERIAL 8'h64

`define MSR_CODE_NONE 8'h00
`define MSR_CODE_ONE 8'h01
`define MSR_CODE_TWO 8'h02
`define MSR_ST_INTERLOCK 3'h3
`define MSR_ST_MUTING 3'h6
`define MSR_ST_FAULT 3'h7
`define MSR_MODE_AUTO 2'h1
`define MSR_MODE_START 2'h2
`define MSR_MODE_RESTART 2'h3

`define MSR_B0_FAULT 7
`define MSR_B0_MUTING 5
`define MSR_B0_ZONE1 4
`define MSR_B0_ZONE2 3
`define MSR_B0_STOP 2
`define MSR_B0_RUN 1
`define MSR_B0_ILOCK 0
`define MSR_B1_TLIMIT 5
`define MSR_B1_MONITOR 4
`define MSR_B1_RESTART 3
`define MSR_B1_START 2
`define MSR_B1_AUTO 1

`define MSR_LEN_BYTE 4'h1
`define MSR_LEN_WORD 4'h4
`define MSR_LEN_IMAGE 4'h8
`define MSR_SENS_BASE 8'h02

`endif

// ### msr_net_master.sv
// network master model: one-cycle requests, answer capture, change counting
`timescale 1ns/1ns
module msr_net_master
(
    input wire sys_clk_i,
    input wire rsp_valid_i,
    input wire rsp_err_i,
    input wire [3:0] rsp_len_i,
    input wire [63:0] rsp_data_i,
    input wire cos_valid_i,
    input wire [7:0] cos_data_i,
    output reg req_valid_o,
    output reg [1:0] req_kind_o,
    output reg req_write_o,
    output reg [7:0] req_class_o,
    output reg [7:0] req_inst_o,
    output reg [7:0] req_attr_o
);
    reg got_ok, got_err;
    reg [3:0] got_len;
    reg [63:0] got_data;
    reg [7:0] cos_last;
    integer cos_cnt;
    initial
    begin
        {req_valid_o, req_kind_o, req_write_o} = 4'h0;
        {req_class_o, req_inst_o, req_attr_o} = 24'h0;
        cos_cnt = 0;
    end
    // sampled mid-cycle, where the one-cycle pulse has settled
    always @(negedge sys_clk_i)
        if (cos_valid_i === 1'b1)
        begin
            cos_cnt <= cos_cnt + 1;
            cos_last <= cos_data_i;
        end
    // status is only observed; a write is sent only when a test asks for refusal
    task xfer(input [1:0] k, input w, input [7:0] c, input [7:0] i, input [7:0] a);
        begin
            @(negedge sys_clk_i);
            {req_valid_o, req_kind_o, req_write_o} = {1'b1, k, w};
            {req_class_o, req_inst_o, req_attr_o} = {c, i, a};
            @(negedge sys_clk_i);
            // the answer stands for just the cycle around this falling edge
            {got_ok, got_err, got_len, got_data} = {rsp_valid_i, rsp_err_i, rsp_len_i, rsp_data_i};
            req_valid_o = 1'b0;
            // released fields must not look like a repeat of the request
            {req_class_o, req_inst_o, req_attr_o} = ~{c, i, a};
        end
    endtask
endmodule // msr_net_master

// ### msr_status_responder.v
// read-only status responder for the muting controller network port
`timescale 1ns/1ns
`include "msr_consts.vh"

module msr_status_responder
(
    input wire sys_clk_i,
    input wire rst_i,
    // request side, one-cycle strobe
    input wire req_valid_i,
    input wire [1:0] req_kind_i,
    input wire req_write_i,
    input wire [7:0] req_class_i,
    input wire [7:0] req_inst_i,
    input wire [7:0] req_attr_i,
    // muting controller state, same clock
    input wire status_valid_i,
    input wire [1:0] op_mode_i,
    input wire [2:0] mach_state_i,
    input wire [3:0] zone_pair_i,
    input wire [1:0] safety_output_pair_i,
    input wire machine_control_element_check_i,
    input wire bypass_en_i,
    input wire mute_en_i,
    input wire two_curtains_i,
    input wire [1:0] sens_cnt_i,
    input wire time_unlimited_i,
    input wire aux_follow_i,
    input wire [7:0] sensor_blocked_i,
    input wire [7:0] err_code_i,
    input wire [7:0] fw_version_i,
    input wire [31:0] serial_i,
    // answer side
    output reg rsp_valid_o,
    output reg rsp_err_o,
    output reg [3:0] rsp_len_o,
    output reg [63:0] rsp_data_o,
    // unsolicited change message
    output reg cos_valid_o,
    output reg [7:0] cos_data_o
);

////////////////////////////////////////////////////////////////////////////////
// encoding helpers

function [7:0] msr_pick;
    input second;
    begin
        msr_pick = second ? `MSR_CODE_TWO : `MSR_CODE_ONE;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// status images

wire zone1_clear;
wire zone2_clear;
wire outs_on;
wire outs_off;
reg [7:0] byte0;
reg [7:0] byte1;
wire [63:0] strobe_img;
wire [7:0] curtain_code;
wire [7:0] sens_code;
wire [7:0] sens_per_chan;

// a zone is clear only while both of its zone-pair inputs are on
assign zone1_clear = &zone_pair_i[1:0];
assign zone2_clear = &zone_pair_i[3:2];
assign outs_on = &safety_output_pair_i;
assign outs_off = ~|safety_output_pair_i;

assign curtain_code = msr_pick(two_curtains_i);
assign sens_code = {6'h00, sens_cnt_i} + `MSR_CODE_ONE;
assign sens_per_chan = {6'h00, sens_cnt_i} + `MSR_SENS_BASE;

always @*
begin
    byte0 = 8'h00;
    byte0[`MSR_B0_FAULT] = (mach_state_i == `MSR_ST_FAULT); // [R15]
    byte0[`MSR_B0_MUTING] = (mach_state_i == `MSR_ST_MUTING); // [R15]
    byte0[`MSR_B0_ZONE1] = zone1_clear; // [R15]
    byte0[`MSR_B0_ZONE2] = zone2_clear; // [R15]
    byte0[`MSR_B0_STOP] = outs_off; // [R23]
    byte0[`MSR_B0_RUN] = outs_on; // [R23]
    byte0[`MSR_B0_ILOCK] = (mach_state_i == `MSR_ST_INTERLOCK); // [R15]
end

always @*
begin
    byte1 = 8'h00;
    byte1[`MSR_B1_TLIMIT] = ~time_unlimited_i; // [R17]
    byte1[`MSR_B1_MONITOR] = machine_control_element_check_i; // [R17]
    byte1[`MSR_B1_RESTART] = (op_mode_i == `MSR_MODE_RESTART); // [R17]
    byte1[`MSR_B1_START] = (op_mode_i == `MSR_MODE_START); // [R17]
    byte1[`MSR_B1_AUTO] = (op_mode_i == `MSR_MODE_AUTO); // [R17]
end

// byte 0 sits in the low lane; bytes 2, 3 and 7 read as zero
assign strobe_img = {8'h00, sens_per_chan, curtain_code, err_code_i,
                     16'h0000, byte1, byte0}; // [R16] [R18]

////////////////////////////////////////////////////////////////////////////////
// attribute decode for explicit reads

reg [7:0] attr_val;
reg attr_hit;
reg attr_coded;

always @*
begin
    attr_val = `MSR_CODE_NONE;
    attr_hit = 1'b1;
    attr_coded = 1'b1;
    case (req_attr_i)
        `MSR_A_MODE:
            attr_val = {6'h00, op_mode_i}; // [R3]
        `MSR_A_STATE:
            attr_val = {5'h00, mach_state_i}; // [R4]
        `MSR_A_ZONE1:
            attr_val = msr_pick(~zone1_clear); // [R5]
        `MSR_A_ZONE2:
            attr_val = msr_pick(~zone2_clear); // [R5]
        `MSR_A_RELAY:
            attr_val = msr_pick(outs_on); // [R6]
        `MSR_A_MONITOR:
            attr_val = msr_pick(~machine_control_element_check_i); // [R7]
        `MSR_A_BYPASS:
            attr_val = msr_pick(~bypass_en_i); // [R7]
        `MSR_A_MUTE:
            attr_val = msr_pick(~mute_en_i); // [R7]
        `MSR_A_CURTAINS:
            attr_val = curtain_code; // [R8]
        `MSR_A_SENSORS:
            attr_val = sens_code; // [R9]
        `MSR_A_TLIMIT:
            attr_val = msr_pick(time_unlimited_i); // [R10]
        `MSR_A_AUX:
            attr_val = msr_pick(aux_follow_i); // [R11]
        `MSR_A_S1A:
            attr_val = msr_pick(sensor_blocked_i[0]); // [R12]
        `MSR_A_S1B:
            attr_val = msr_pick(sensor_blocked_i[1]); // [R12]
        `MSR_A_S1C:
            attr_val = msr_pick(sensor_blocked_i[2]); // [R12]
        `MSR_A_S1D:
            attr_val = msr_pick(sensor_blocked_i[3]); // [R12]
        `MSR_A_S2A:
            attr_val = msr_pick(sensor_blocked_i[4]); // [R12]
        `MSR_A_S2B:
            attr_val = msr_pick(sensor_blocked_i[5]); // [R12]
        `MSR_A_S2C:
            attr_val = msr_pick(sensor_blocked_i[6]); // [R12]
        `MSR_A_S2D:
            attr_val = msr_pick(sensor_blocked_i[7]); // [R12]
        `MSR_A_ERROR:
        begin
            attr_val = err_code_i; // [R21]
            attr_coded = 1'b0;
        end
        `MSR_A_FWVER:
        begin
            attr_val = fw_version_i; // [R22]
            attr_coded = 1'b0;
        end
        default:
        begin
            attr_hit = 1'b0;
            attr_coded = 1'b0;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// answer selection

reg [63:0] rsp_data_next;
reg [3:0] rsp_len_next;
reg rsp_err_next;
wire is_status;
wire is_asm;

assign is_status = (req_class_i == `MSR_CLS_STATUS) &&
                   (req_inst_i == `MSR_INST_ONE); // [R2]
assign is_asm = (req_class_i == `MSR_CLS_ASM) &&
                (req_attr_i == `MSR_ASM_ATTR);

always @*
begin
    rsp_data_next = 64'h0000000000000000;
    rsp_len_next = `MSR_LEN_BYTE;
    rsp_err_next = 1'b0;
    case (req_kind_i)
        `MSR_KIND_POLL:
            rsp_data_next = {56'h0, byte0}; // [R14]
        `MSR_KIND_STRB:
        begin
            rsp_data_next = strobe_img; // [R16]
            rsp_len_next = `MSR_LEN_IMAGE;
        end
        `MSR_KIND_EXPL:
        begin
            // nothing on the network may change controller state
            if (req_write_i)
            begin
                rsp_err_next = 1'b1; // [R1]
                rsp_len_next = 4'h0;
            end
            else if (is_status && req_attr_i == `MSR_A_SERIAL)
            begin
                rsp_data_next = {32'h0, serial_i}; // [R13]
                rsp_len_next = `MSR_LEN_WORD;
            end
            else if (is_status && attr_hit)
            begin
                // zero means no data while the controller has none to give
                if (attr_coded && !status_valid_i)
                    rsp_data_next = {56'h0, `MSR_CODE_NONE}; // [R2]
                else
                    rsp_data_next = {56'h0, attr_val}; // [R2]
            end
            else if (is_asm && (req_inst_i == `MSR_INST_ONE ||
                                req_inst_i == `MSR_INST_THREE))
                rsp_data_next = {56'h0, byte0}; // [R14] [R20]
            else if (is_asm && req_inst_i == `MSR_INST_TWO)
            begin
                rsp_data_next = strobe_img; // [R16]
                rsp_len_next = `MSR_LEN_IMAGE;
            end
            else
            begin
                rsp_err_next = 1'b1;
                rsp_len_next = 4'h0;
            end
        end
        default:
        begin
            rsp_err_next = 1'b1;
            rsp_len_next = 4'h0;
        end
    endcase
    // a write is never honoured, whatever kind of request carries it
    if (req_write_i)
    begin
        rsp_err_next = 1'b1; // [R1]
        rsp_len_next = 4'h0;
        rsp_data_next = 64'h0000000000000000;
    end
end

always @(posedge sys_clk_i)
begin
    if (rst_i)
    begin
        rsp_valid_o <= 1'b0;
        rsp_err_o <= 1'b0;
        rsp_len_o <= 4'h0;
        rsp_data_o <= 64'h0000000000000000;
    end
    else
    begin
        rsp_valid_o <= req_valid_i;
        if (req_valid_i)
        begin
            rsp_err_o <= rsp_err_next;
            rsp_len_o <= rsp_len_next;
            rsp_data_o <= rsp_data_next;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// change_status_image on byte 0

reg [7:0] last_byte0_reg;
reg primed_reg;

// the first cycle after reset only takes a reference, so reset itself
// never produces a spurious change message
always @(posedge sys_clk_i)
begin
    if (rst_i)
    begin
        last_byte0_reg <= 8'h00;
        primed_reg <= 1'b0;
        cos_valid_o <= 1'b0;
        cos_data_o <= 8'h00;
    end
    else
    begin
        last_byte0_reg <= byte0;
        primed_reg <= 1'b1;
        cos_valid_o <= primed_reg && (byte0 != last_byte0_reg); // [R19]
        if (primed_reg && (byte0 != last_byte0_reg))
            cos_data_o <= byte0; // [R20]
    end
end

endmodule // msr_status_responder

// ### msr_status_responder_bench.sv
// self-checking bench for the status responder
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks = num_checks + 1; if ((a) !== (b)) begin \
    n_fail = n_fail + 1; $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module msr_status_responder_bench;
    reg clk, rst, sv, mce, byp, mute, two, unl, aux;
    reg [1:0] mode, sop, sens;
    reg [2:0] ms;
    reg [3:0] zp;
    reg [7:0] sb, err;
    wire rv, re, cv, qv, qw;
    wire [1:0] qk;
    wire [3:0] rl;
    wire [7:0] qc, qi, qa, cd;
    wire [63:0] rd;
    integer n_fail, num_checks, cyc, a, k;
    reg kn;
    reg [67:0] img;
    localparam [34:0] SA = {2'h1, 3'h2, 4'h7, 2'h3, 4'hA, 2'h1, 2'h1, 8'hA5, 8'h00};
    msr_status_responder i_msr_status_responder (.sys_clk_i(clk), .rst_i(rst),
        .req_valid_i(qv), .req_kind_i(qk), .req_write_i(qw), .req_class_i(qc),
        .req_inst_i(qi), .req_attr_i(qa), .status_valid_i(sv), .op_mode_i(mode),
        .mach_state_i(ms), .zone_pair_i(zp), .safety_output_pair_i(sop),
        .machine_control_element_check_i(mce), .bypass_en_i(byp), .mute_en_i(mute),
        .two_curtains_i(two), .sens_cnt_i(sens), .time_unlimited_i(unl), .aux_follow_i(aux),
        .sensor_blocked_i(sb), .err_code_i(err), .fw_version_i(8'h3C),
        .serial_i(32'h1234ABCD), .rsp_valid_o(rv), .rsp_err_o(re), .rsp_len_o(rl),
        .rsp_data_o(rd), .cos_valid_o(cv), .cos_data_o(cd));
    msr_net_master i_msr_net_master (.sys_clk_i(clk), .rsp_valid_i(rv), .rsp_err_i(re),
        .rsp_len_i(rl), .rsp_data_i(rd), .cos_valid_i(cv), .cos_data_i(cd),
        .req_valid_o(qv), .req_kind_o(qk), .req_write_o(qw), .req_class_o(qc),
        .req_inst_o(qi), .req_attr_o(qa));
    function [7:0] cc(input b);
        cc = b ? 8'h02 : 8'h01;
    endfunction
    function [7:0] ex(input [7:0] x);
        begin
            case (x)
                8'h01: ex = mode;
                8'h02: ex = ms;
                8'h03: ex = cc(zp[1:0] != 2'h3);
                8'h04: ex = cc(zp[3:2] != 2'h3);
                8'h05: ex = cc(sop == 2'h3);
                8'h06: ex = cc(!mce);
                8'h07: ex = cc(!byp);
                8'h08: ex = cc(two);
                8'h09: ex = sens + 8'h01;
                8'h0A: ex = cc(unl);
                8'h0B: ex = cc(aux);
                8'h10: ex = cc(sb[4]);
                8'h19: ex = err;
                8'h22: ex = 8'h3C;
                8'h2B: ex = cc(!mute);
                default: ex = cc(sb[x < 8'h10 ? x - 8'h0C : x - 8'h1A]);
            endcase
            // coded values read zero while the controller state is not meaningful
            if (!sv && x != 8'h19 && x != 8'h22)
                ex = 8'h00;
        end
    endfunction
    function [7:0] b0(input d);
        b0 = {ms == 3'h7, 1'b0, ms == 3'h6, zp[1:0] == 2'h3, zp[3:2] == 2'h3,
            sop == 2'h0, sop == 2'h3, ms == 3'h3};
    endfunction
    task rq(input [1:0] k, input w, input [7:0] c, input [7:0] i, input [7:0] a);
        begin
            i_msr_net_master.xfer(k, w, c, i, a);
            `CHK(i_msr_net_master.got_ok, 1'b1)
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            n_fail = n_fail + 1;
            conclude;
        end
    end
    initial
    begin
        {rst, sv, n_fail, num_checks, cyc} = {2'h3, 96'h0};
        {mode, ms, zp, sop, mce, byp, mute, two, sens, unl, aux, sb, err} = SA;
        repeat (12) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        for (k = 0; k < 3; k = k + 1)
        begin
            @(negedge clk) {mode, ms, zp, sop, mce, byp, mute, two, sens, unl, aux, sb, err} =
                k == 1 ? ~SA : SA;
            sv = k != 2;
            for (a = 0; a < 48; a = a + 1)
            begin
                rq(2'h0, 1'b0, 8'h64, 8'h01, a);
                kn = a < 17 && a > 0 || a == 25 || a > 30 && a < 35 || a == 43;
                `CHK(i_msr_net_master.got_err, !kn)
                `CHK(i_msr_net_master.got_len, {3'h0, kn})
                `CHK(i_msr_net_master.got_data, kn ? ex(a) : 8'h00)
            end
            $display("attribute pass %0d done", k);
        end
        rq(2'h0, 1'b0, 8'h64, 8'h01, 8'h64);
        `CHK({i_msr_net_master.got_len, i_msr_net_master.got_data}, {4'h4, 64'h1234ABCD})
        rq(2'h0, 1'b1, 8'h64, 8'h01, 8'h02);
        `CHK({i_msr_net_master.got_err, i_msr_net_master.got_len}, 5'h10)
        rq(2'h3, 1'b0, 8'h04, 8'h01, 8'h03);
        `CHK({i_msr_net_master.got_err, i_msr_net_master.got_len}, 5'h10)
        rq(2'h0, 1'b0, 8'h64, 8'h02, 8'h02);
        `CHK(i_msr_net_master.got_err, 1'b1)
        $display("serial and refusal done");
        sv = 1'b1;
        for (k = 1; k < 8; k = k + 1)
        begin
            @(negedge clk) {ms, mode} = {k[2:0], k[1:0]};
            rq(2'h1, 1'b0, 8'h04, 8'h01, 8'h03);
            img = {4'h1, 56'h0, b0(0)};
            `CHK({i_msr_net_master.got_len, i_msr_net_master.got_data}, img)
            rq(k == 7 ? 2'h0 : 2'h2, 1'b0, 8'h04, 8'h02, 8'h03);
            img = {4'h8, 8'h00, sens + 8'h02, cc(two), err, 16'h0000, 2'h0, !unl, mce,
                mode == 2'h3, mode == 2'h2, mode == 2'h1, 1'b0, b0(0)};
            `CHK({i_msr_net_master.got_len, i_msr_net_master.got_data}, img)
            rq(2'h0, 1'b0, 8'h04, k[0] ? 8'h01 : 8'h03, 8'h03);
            `CHK(i_msr_net_master.got_data, {56'h0, b0(0)})
        end
        $display("status image done");
        @(negedge clk) sop = 2'h0;
        repeat (3) @(negedge clk);
        a = i_msr_net_master.cos_cnt;
        sop = 2'h3;
        repeat (6) @(negedge clk);
        `CHK(i_msr_net_master.cos_cnt, a + 1)
        `CHK(i_msr_net_master.cos_last, b0(0))
        $display("change message done");
        conclude;
    end
endmodule // msr_status_responder_bench

// ### msr_status_responder_properties.sv
// port-level checks for the status responder
`timescale 1ns/1ns
module msr_checker
(
    input wire sys_clk_i,
    input wire rst_i,
    input wire req_valid_i,
    input wire [1:0] req_kind_i,
    input wire req_write_i,
    input wire [7:0] req_class_i,
    input wire [7:0] req_inst_i,
    input wire [7:0] req_attr_i,
    input wire status_valid_i,
    input wire [2:0] mach_state_i,
    input wire [3:0] zone_pair_i,
    input wire [1:0] safety_output_pair_i,
    input wire rsp_valid_o,
    input wire rsp_err_o,
    input wire [3:0] rsp_len_o,
    input wire [63:0] rsp_data_o,
    input wire cos_valid_o,
    input wire [7:0] cos_data_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire rd = req_valid_i && !req_write_i;
    wire [1:0] sop = safety_output_pair_i;
    // everything the status byte is built from, plus status_valid_i
    wire [9:0] src = {status_valid_i, mach_state_i, zone_pair_i, sop};
    AST_ANSWER: assert property (req_valid_i |=> rsp_valid_o)
        else $error("no answer after request");
    AST_NO_EXTRA: assert property (!req_valid_i |=> !rsp_valid_o)
        else $error("answer without request");
    AST_WRITE: assert property (req_valid_i && req_write_i |=> rsp_err_o && rsp_len_o == 4'h0)
        else $error("write not refused");
    AST_KIND3: assert property (rd && req_kind_i == 2'h3 |=> rsp_err_o && rsp_len_o == 4'h0)
        else $error("illegal kind not refused");
    AST_STATE: assert property (rd && req_kind_i == 2'h0 && req_class_i == 8'h64
        && req_inst_i == 8'h01 && req_attr_i == 8'h02 && status_valid_i
        |=> rsp_data_o[7:0] == {5'h00, $past(mach_state_i)}) else $error("state code wrong");
    AST_POLL: assert property (rd && req_kind_i == 2'h1 |=> rsp_len_o == 4'h1
        && rsp_data_o[63:8] == 56'h0 && !rsp_data_o[6] && rsp_data_o[1] == ($past(sop) == 2'h3))
        else $error("poll image wrong");
    AST_STROBE: assert property (rd && req_kind_i == 2'h2 |=> rsp_len_o == 4'h8
        && rsp_data_o[31:16] == 16'h0 && rsp_data_o[2] == ($past(sop) == 2'h0))
        else $error("strobe image wrong");
    AST_COS_FIRE: assert property ($past(sop) == ~sop && sop[0] == sop[1] && !$past(rst_i)
        |=> cos_valid_o && cos_data_o[1] == $past(sop[0])) else $error("change not sent");
    AST_COS_QUIET: assert property ($stable(src) |=> !cos_valid_o)
        else $error("change message without change");
endmodule // msr_checker

bind msr_status_responder msr_checker i_msr_checker (.sys_clk_i, .rst_i, .req_valid_i,
    .req_kind_i, .req_write_i, .req_class_i, .req_inst_i, .req_attr_i, .status_valid_i,
    .mach_state_i, .zone_pair_i, .safety_output_pair_i, .rsp_valid_o, .rsp_err_o,
    .rsp_len_o, .rsp_data_o, .cos_valid_o, .cos_data_o);
